// *** utc_map.svh ***
// constants for the transceiver transmit control block
`ifndef UTC_MAP_SVH
`define UTC_MAP_SVH
`define UTC_XCVR_HS 2'h0
`define UTC_XCVR_FS 2'h1
`define UTC_XCVR_LS 2'h2
`define UTC_XCVR_LSFS 2'h3
`define UTC_TERM_HS 1'h0
`define UTC_TERM_FS 1'h1
`define UTC_OPM_NORMAL 2'h0
`define UTC_OPM_NODRIVE 2'h1
`define UTC_OPM_RAW 2'h2
`define UTC_SYNC_HS 8'h20
`define UTC_SYNC_FS 8'h08
`define UTC_SYNC_BYTE 8'h80
`define UTC_EOP_HS 8'h08
`define UTC_EOP_FS 8'h03
`define UTC_DIV_HS 6'h00
`define UTC_DIV_FS 6'h27
`define UTC_DIV_LS 6'h3f
`define UTC_ZERO8 8'h00
`endif

// *** utc_pkg.sv ***
// types for the transceiver transmit control block
package utc_pkg;
	// transmit state machine
	typedef enum logic [2:0]
	{
		UTC_IDLE = 3'b000,
		UTC_SYNC = 3'b001,
		UTC_DATA = 3'b010,
		UTC_EOP = 3'b011
	} utc_tx_state_t;
	// control inputs bundle
	typedef struct packed
	{
		logic [1:0] speed_xcvr_select;
		logic termination_select;
		logic [1:0] operating_mode_select;
		logic low_power_suspend_n;
		logic host_mode;
	} utc_ctrl_t;
	// line side drive bundle
	typedef struct packed
	{
		logic line_enable;
		logic [7:0] line_byte;
		logic sync_active;
		logic eop_active;
		logic stuff_nrzi_enable;
		logic hs_termination;
		logic fs_termination;
		logic pullup_resistor;
		logic pulldown_resistor;
		logic [1:0] speed_mode;
		logic fs_edge_rate;
	} utc_line_t;
	// whole module state
	typedef struct packed
	{
		utc_tx_state_t state;
		logic [7:0] hold;
		logic [7:0] count;
		logic [5:0] div;
		logic tx_byte_accepted;
		logic valid_d;
		utc_line_t line;
	} utc_state_t;
endpackage : utc_pkg

// *** utc_tx_control.sv ***
// transmit handshake, SYNC/EOP sequencing and mode control of the transceiver
`timescale 1ns/10ps
`include "utc_map.svh"
module utc_tx_control
	import utc_pkg::*;
(
	input wire logic i_clock, // interface clock
	input wire logic i_rst_n, // async reset, active low
	input wire utc_ctrl_t i_ctrl, // mode and suspend controls
	input wire logic i_tx_byte_valid, // link byte valid
	input wire logic [7:0] i_tx_data, // link transmit byte
	output logic o_tx_byte_accepted, // byte taken pulse
	output logic o_interface_clock_enable, // interface clock gate
	output utc_line_t o_line // line side drive
);
	// ----------------------------------------
	// state registers
	// ----------------------------------------
	utc_state_t r;
	utc_state_t next_r;
	logic bit_tick; // one byte time at the selected speed
	logic [5:0] div_top; // divider reload per speed

	// ----------------------------------------
	// next state logic
	// ----------------------------------------
	// byte pacing and handshake
	always_comb
	begin
		next_r = r;
		next_r.tx_byte_accepted = 1'b0;
		next_r.valid_d = i_tx_byte_valid;
		unique case (i_ctrl.speed_xcvr_select)
			`UTC_XCVR_HS: div_top = `UTC_DIV_HS;
			`UTC_XCVR_FS: div_top = `UTC_DIV_FS;
			`UTC_XCVR_LS: div_top = `UTC_DIV_LS;
			`UTC_XCVR_LSFS: div_top = `UTC_DIV_LS;
		endcase
		bit_tick = (r.div == 6'h00);
		// byte pacing divider
		if (r.state == UTC_IDLE || bit_tick)
		begin
			next_r.div = div_top;
		end
		else
		begin
			next_r.div = r.div - 6'h01;
		end
		next_r.line.speed_mode = i_ctrl.speed_xcvr_select;
		next_r.line.fs_edge_rate = (i_ctrl.speed_xcvr_select != `UTC_XCVR_LS);
		next_r.line.hs_termination = (i_ctrl.termination_select == `UTC_TERM_HS);
		next_r.line.fs_termination = (i_ctrl.termination_select == `UTC_TERM_FS);
		next_r.line.stuff_nrzi_enable = (i_ctrl.operating_mode_select != `UTC_OPM_RAW);
		if (i_ctrl.operating_mode_select == `UTC_OPM_NODRIVE)
		begin
			// non-driving: all terminations removed
			next_r.line.hs_termination = 1'b0;
			next_r.line.fs_termination = 1'b0;
		end
		// resistor control
		next_r.line.pullup_resistor = ~i_ctrl.host_mode & next_r.line.fs_termination;
		next_r.line.pulldown_resistor = i_ctrl.host_mode;
		if (!i_ctrl.low_power_suspend_n)
		begin
			if (i_ctrl.host_mode)
			begin
				next_r.line.pullup_resistor = 1'b0;
			end
			else
			begin
				next_r.line.pulldown_resistor = ~i_ctrl.termination_select;
			end
		end
		// transmit state machine
		unique case (r.state)
			UTC_IDLE:
			begin
				next_r.line.line_enable = 1'b0;
				next_r.line.sync_active = 1'b0;
				next_r.line.eop_active = 1'b0;
				if (i_tx_byte_valid && !r.valid_d && i_ctrl.low_power_suspend_n &&
					i_ctrl.operating_mode_select != `UTC_OPM_NODRIVE)
				begin
					next_r.state = UTC_SYNC;
					next_r.count = (i_ctrl.speed_xcvr_select == `UTC_XCVR_HS) ? `UTC_SYNC_HS : `UTC_SYNC_FS;
					next_r.line.line_enable = 1'b1;
					next_r.line.sync_active = 1'b1;
					next_r.line.line_byte = `UTC_SYNC_BYTE;
				end
			end
			UTC_SYNC:
			begin
				if (bit_tick)
				begin
					next_r.count = r.count - 8'h01;
					if (r.count == 8'h01)
					begin
						next_r.state = UTC_DATA;
						next_r.line.sync_active = 1'b0;
					end
				end
			end
			UTC_DATA:
			begin
				if (bit_tick)
				begin
					if (!i_tx_byte_valid)
					begin
						next_r.state = UTC_EOP;
						next_r.line.eop_active = 1'b1;
						next_r.line.line_byte = `UTC_ZERO8;
						next_r.count = (i_ctrl.speed_xcvr_select == `UTC_XCVR_HS) ? `UTC_EOP_HS : `UTC_EOP_FS;
					end
					else
					begin
						next_r.hold = i_tx_data;
						next_r.line.line_byte = i_tx_data;
						next_r.tx_byte_accepted = 1'b1;
					end
				end
			end
			UTC_EOP:
			begin
				if (bit_tick)
				begin
					next_r.count = r.count - 8'h01;
					if (r.count == 8'h01)
					begin
						next_r.state = UTC_IDLE;
						next_r.line.eop_active = 1'b0;
						next_r.line.line_enable = 1'b0;
					end
				end
			end
			default:
			begin
				next_r.state = UTC_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// reset to initial state
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// ready marks the edge that takes the byte
	// combinational so the link advances on the very edge the byte is captured;
	// a registered copy would let the next tick capture the old byte again
	assign o_tx_byte_accepted = (r.state == UTC_DATA) && bit_tick && i_tx_byte_valid;
	assign o_interface_clock_enable = i_ctrl.low_power_suspend_n;
	assign o_line = r.line;
endmodule : utc_tx_control

// *** utc_tx_control_assertions.sv ***
// port checks for the transmit control block
`timescale 1ns/10ps
module utc_tx_control_assertions
	import utc_pkg::*;
(
	input wire logic i_clock, // clock
	input wire logic i_rst_n, // reset
	input wire utc_ctrl_t i_ctrl, // controls
	input wire logic i_tx_byte_valid, // valid
	input wire logic [7:0] i_tx_data, // byte
	input wire logic o_tx_byte_accepted, // taken
	input wire logic o_interface_clock_enable, // gate
	input wire utc_line_t o_line // line
);
	wire sn = i_ctrl.low_power_suspend_n; // awake
	wire hm = i_ctrl.host_mode; // host
	wire ts = i_ctrl.termination_select; // fs term
	wire go = sn && i_ctrl.operating_mode_select != 2'h1; // may drive
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// valid rising from idle
	sequence s_start;
		$rose(i_tx_byte_valid) && !o_line.line_enable;
	endsequence
	a_sync_start: assert property (s_start ##0 go |-> ##[1:2] o_line.sync_active)
		else $error("no sync");
	a_start_refused: assert property (s_start ##0 !go |=> !o_line.line_enable)
		else $error("start not refused");
	a_eop_start: assert property ($fell(i_tx_byte_valid) && o_line.line_enable && !o_line.sync_active
		|-> ##[1:70] o_line.eop_active) else $error("no eop");
	a_term_follow: assert property ($past(i_rst_n) && $past(go && !i_ctrl.operating_mode_select[1])
		|-> o_line.hs_termination == !$past(ts)) else $error("bad termination");
	a_host_pullup: assert property ($past(i_rst_n) && $past(!sn && hm) |-> !o_line.pullup_resistor)
		else $error("pullup kept");
	a_dev_pulldown: assert property ($past(i_rst_n) && $past(!sn && !hm)
		|-> o_line.pulldown_resistor == !$past(ts)) else $error("bad pulldown");
	a_clock_gate: assert property (o_interface_clock_enable == sn)
		else $error("bad clock gate");
	a_reset_clear: assert property ($rose(i_rst_n) |-> o_line == '0 && !o_tx_byte_accepted)
		else $error("not cleared");
endmodule : utc_tx_control_assertions
bind utc_tx_control utc_tx_control_assertions chk_u (.i_clock, .i_rst_n, .i_ctrl, .i_tx_byte_valid,
	.i_tx_data, .o_tx_byte_accepted, .o_interface_clock_enable, .o_line);

// *** utc_link_model.sv ***
// link side model streaming bytes
`timescale 1ns/10ps
module utc_link_model
(
	input wire logic i_clock, // clock
	input wire logic i_go, // send packet
	input wire logic [7:0] i_len, // length
	input wire logic i_accepted, // taken
	output logic o_valid = 1'b0, // valid
	output logic [7:0] o_data = 8'h00, // byte
	output logic [7:0] o_sent = 8'h00 // count
);
	// ready only looked at while valid is high
	// mode inputs are never touched here
	always @(posedge i_clock)
	begin
		if (!i_go)
		begin
			o_valid <= 1'b0;
			o_sent <= 8'h00;
		end
		else if (o_valid && i_accepted)
		begin
			o_sent <= o_sent + 8'h01;
			o_data <= o_data + 8'h01;
			o_valid <= o_sent + 8'h01 != i_len;
		end
		else if (o_sent != i_len)
			o_valid <= 1'b1;
	end
endmodule : utc_link_model

// *** utc_tx_control_tb_top.sv ***
// bench for the transmit control block
`timescale 1ns/10ps
module utc_tx_control_tb_top
	import utc_pkg::*;
;
	logic clock = 1'b0; // 50 MHz
	logic rst_n = 1'b0; // reset
	utc_ctrl_t ctrl = 7'h02; // hs, awake
	logic go = 1'b0; // start
	logic [7:0] len = 8'h04; // length
	logic valid, acc, cen, eop_seen;
	logic [7:0] data, sent;
	utc_line_t line;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	always #10 clock = ~clock;
	utc_tx_control dut_u (.i_clock(clock), .i_rst_n(rst_n), .i_ctrl(ctrl), .i_tx_byte_valid(valid),
		.i_tx_data(data), .o_tx_byte_accepted(acc), .o_interface_clock_enable(cen), .o_line(line));
	utc_link_model link_u (.i_clock(clock), .i_go(go), .i_len(len), .i_accepted(acc),
		.o_valid(valid), .o_data(data), .o_sent(sent));
	// timeout and eop watch
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (line.eop_active === 1'b1)
			eop_seen <= 1'b1;
		if (cycles == 5000)
		begin
			miscompares++;
			end_sim();
		end
	end
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task end_sim;
		$display("compares %0d errors %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task t_modes;
		for (int i = 0; i < 4; i++)
		begin
			ctrl.speed_xcvr_select = 2'(i);
			ctrl.termination_select = i[0];
			step(2);
			chk("edge", 8'(i != 2), 8'(line.fs_edge_rate));
			chk("hsterm", 8'(!i[0]), 8'(line.hs_termination));
		end
		$display("modes done");
	endtask : t_modes
	task t_pkt(input logic [1:0] spd, input logic [7:0] n);
		ctrl.speed_xcvr_select = spd;
		ctrl.termination_select = spd != 2'h0;
		len = n;
		eop_seen = 1'b0;
		step(2);
		go = 1'b1;
		while (sent !== n)
			step(1);
		chk("sent", n, sent);
		chk("lastbyte", data - 8'h01, line.line_byte);
		go = 1'b0;
		while (line.line_enable !== 1'b0)
			step(1);
		chk("eop", 8'h01, 8'(eop_seen));
		$display("packet done");
	endtask : t_pkt
	task t_refuse;
		ctrl.host_mode = 1'b1;
		ctrl.low_power_suspend_n = 1'b0;
		go = 1'b1;
		step(4);
		chk("clken", 8'h00, 8'(cen));
		chk("pullup", 8'h00, 8'(line.pullup_resistor));
		chk("drive", 8'h00, 8'(line.line_enable));
		go = 1'b0;
		ctrl.host_mode = 1'b0;
		for (int t = 0; t < 2; t++)
		begin
			ctrl.termination_select = t[0];
			step(2);
			chk("pulldown", 8'(!t[0]), 8'(line.pulldown_resistor));
		end
		ctrl.low_power_suspend_n = 1'b1;
		ctrl.operating_mode_select = 2'h1;
		step(2);
		go = 1'b1;
		step(4);
		chk("nodrive", 8'h00, 8'(line.line_enable));
		go = 1'b0;
		step(2);
		ctrl.operating_mode_select = 2'h0;
		$display("refuse done");
	endtask : t_refuse
	task t_reset;
		len = 8'h08;
		go = 1'b1;
		step(20);
		#4 rst_n = 1'b0;
		step(1);
		chk("reset", 8'h00, {6'h00, |line, acc});
		go = 1'b0;
		step(2);
		rst_n = 1'b1;
		step(5);
		$display("reset done");
	endtask : t_reset
	initial
	begin
		step(5);
		rst_n = 1'b1;
		step(5);
		t_modes();
		t_pkt(2'h0, 8'h04);
		t_pkt(2'h1, 8'h02);
		t_refuse();
		t_reset();
		t_pkt(2'h0, 8'h03);
		end_sim();
	end
endmodule : utc_tx_control_tb_top
